// file: rtl/instruction_fetch_front_end.sv
`timescale 1ns/1ps
module instruction_fetch_front_end
  import fetch_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Memory buses behind the arbiter
  output mem_req_t [NUM_BUS-1:0] memReq,
  input wire mem_rsp_t [NUM_BUS-1:0] memRsp,
  // Data port of the execution unit
  input wire mem_req_t execReq,
  output logic execAck,
  output logic [WORD_W-1:0] execRdata,
  // Instruction hand-over
  output logic insnValid,
  output insn_t insn,
  input wire logic insnAccept,
  // Program flow control
  input wire redirect_t redirect,
  input wire logic vecReq,
  input wire logic [ADDR_W-1:0] vecAddr,
  output logic vecAck
);
  logic rstMeta_q, rstn_q;
  fetch_state_t state_q;
  logic [ADDR_W-1:0] fetchPc_q, insnStart_q, pcNext_q;
  logic [BUF_W-1:0] buf_q;
  logic [2:0] byteCnt_q, needBytes_q;
  logic fetchPend_q, fetchStale_q, execPend_q;
  logic execAck_q, vecAck_q, insnValid_q;
  logic [WORD_W-1:0] execRdata_q;
  insn_t insn_q;
  mem_req_t [NUM_BUS-1:0] memReq_q;
  logic [NUM_BUS-1:0] ownExec_q;

  logic [NUM_BUS-1:0] busFree, issueExec, issueFetch;
  logic fetchNeed, execWant, vecStart, take, outFree;
  logic fetchBus, execBus, fetchAck, fetchNarrow, execHit;
  logic [WORD_W-1:0] fetchData, execData;
  logic [2:0] got, newCnt;
  logic [BUF_W-1:0] newBuf;
  logic [ADDR_W-1:0] redirTarget;

  function automatic logic [2:0] bytesFor(input logic [WORD_W-1:0] w);
    case (w[LEN_LSB +: 2])
      LEN_ONE_WORD: bytesFor = BYTES_WORD;
      LEN_TWO_WORDS: bytesFor = BYTES_TWO_WORDS;
      default: bytesFor = BYTES_MAX;
    endcase
  endfunction

  function automatic insn_t packInsn(input logic [BUF_W-1:0] b,
                                     input logic [2:0] n,
                                     input logic [ADDR_W-1:0] a);
    insn_t r;
    r = '0;
    r.addr = a;
    r.words = n[2:1];
    case (n)
      BYTES_WORD: r.op = b[15:0];
      BYTES_TWO_WORDS: begin
        r.op = b[31:16];
        r.ext1 = b[15:0];
      end
      default: begin
        r.op = b[47:32];
        r.ext1 = b[31:16];
        r.ext2 = b[15:0];
      end
    endcase
    packInsn = r;
  endfunction

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstn_q <= rstMeta_q;
    end
  end

  // Bus answers are steered back by who owns each bus
  always_comb begin
    fetchAck = 1'b0;
    fetchNarrow = 1'b0;
    fetchData = '0;
    execHit = 1'b0;
    execData = '0;
    for (int b = 0; b < NUM_BUS; b++) begin
      if (memReq_q[b].req && memRsp[b].ack) begin
        if (ownExec_q[b]) begin
          execHit = 1'b1;
          execData = memRsp[b].rdata;
        end else begin
          fetchAck = 1'b1;
          fetchNarrow = memRsp[b].narrow;
          fetchData = memRsp[b].rdata;
        end
      end
    end
  end

  assign redirTarget = redirect.relative ? pcNext_q + redirect.target
                                         : redirect.target;
  assign vecStart = vecReq && state_q == ST_FIRST && byteCnt_q == BYTES_NONE
                    && !fetchPend_q && !redirect.valid;
  assign fetchNeed = state_q != ST_DONE && !fetchPend_q && !redirect.valid
                     && !vecStart;
  assign execWant = execReq.req && !execPend_q;
  assign fetchBus = fetchPc_q[BUS_SEL_BIT];
  assign execBus = execReq.addr[BUS_SEL_BIT];
  assign take = fetchAck && !fetchStale_q && !redirect.valid;
  // Odd address or 8-bit bus yields a single byte
  assign got = (fetchNarrow || fetchPc_q[0]) ? BYTES_ONE : BYTES_WORD;
  assign newCnt = byteCnt_q + got;
  assign newBuf = (got == BYTES_WORD) ? {buf_q[BUF_W-17:0], fetchData}
                                      : {buf_q[BUF_W-9:0], fetchData[7:0]};
  assign outFree = !insnValid_q || insnAccept;

  generate
    for (genvar b = 0; b < NUM_BUS; b++) begin : g_bus
      assign busFree[b] = !memReq_q[b].req || memRsp[b].ack;
      assign issueExec[b] = execWant && execBus == b && busFree[b];
      // Fetch yields the bus to the execution unit
      assign issueFetch[b] = fetchNeed && fetchBus == b && busFree[b]
                             && !issueExec[b];

      always_ff @(posedge sys_clk or negedge rstn_q) begin
        if (!rstn_q) begin
          memReq_q[b] <= '0;
          ownExec_q[b] <= 1'b0;
        end else if (issueExec[b]) begin
          memReq_q[b] <= execReq;
          ownExec_q[b] <= 1'b1;
        end else if (issueFetch[b]) begin
          memReq_q[b] <= '{req: 1'b1, addr: fetchPc_q, we: 1'b0,
                           wdata: '0};
          ownExec_q[b] <= 1'b0;
        end else if (memRsp[b].ack) begin
          memReq_q[b].req <= 1'b0;
        end
      end

      chk_exec_priority: assert property (@(posedge sys_clk)
        disable iff (!rstn_q)
        execWant && execBus == b && fetchNeed && fetchBus == b && busFree[b]
        |=> ownExec_q[b] && memReq_q[b].addr == $past(execReq.addr))
        else $error("fetch took a bus wanted by execution");
    end
  endgenerate

  // Execution port bookkeeping
  always_ff @(posedge sys_clk or negedge rstn_q) begin
    if (!rstn_q) begin
      execPend_q <= 1'b0;
      execAck_q <= 1'b0;
      execRdata_q <= '0;
    end else begin
      execAck_q <= execHit;
      if (execHit) begin
        execRdata_q <= execData;
      end
      if (|issueExec) begin
        execPend_q <= 1'b1;
      end else if (execAck_q) begin
        execPend_q <= 1'b0;
      end
    end
  end

  // Outstanding fetch; answers to a flushed fetch are dropped
  always_ff @(posedge sys_clk or negedge rstn_q) begin
    if (!rstn_q) begin
      fetchPend_q <= 1'b0;
      fetchStale_q <= 1'b0;
    end else begin
      if (|issueFetch) begin
        fetchPend_q <= 1'b1;
      end else if (fetchAck) begin
        fetchPend_q <= 1'b0;
      end
      if (fetchAck) begin
        fetchStale_q <= 1'b0;
      end else if (redirect.valid && fetchPend_q) begin
        fetchStale_q <= 1'b1;
      end
    end
  end

  // Fetch sequencing and program counter
  always_ff @(posedge sys_clk or negedge rstn_q) begin
    if (!rstn_q) begin
      state_q <= ST_VEC;
      fetchPc_q <= RESET_VEC_ADDR;
      insnStart_q <= '0;
      byteCnt_q <= BYTES_NONE;
      needBytes_q <= BYTES_WORD;
      buf_q <= '0;
    end else if (redirect.valid) begin
      state_q <= ST_FIRST;
      fetchPc_q <= redirTarget;
      insnStart_q <= redirTarget;
      byteCnt_q <= BYTES_NONE;
    end else if (vecStart) begin
      state_q <= ST_VEC;
      fetchPc_q <= vecAddr;
      byteCnt_q <= BYTES_NONE;
    end else if (take) begin
      buf_q <= newBuf;
      byteCnt_q <= newCnt;
      fetchPc_q <= fetchPc_q + ADDR_W'(got);
      case (state_q)
        ST_VEC: begin
          if (newCnt == BYTES_VEC) begin
            state_q <= ST_FIRST;
            fetchPc_q <= newBuf[ADDR_W-1:0];
            insnStart_q <= newBuf[ADDR_W-1:0];
            byteCnt_q <= BYTES_NONE;
          end
        end
        ST_FIRST: begin
          if (newCnt == BYTES_WORD) begin
            needBytes_q <= bytesFor(newBuf[WORD_W-1:0]);
            state_q <= (bytesFor(newBuf[WORD_W-1:0]) == BYTES_WORD)
                       ? ST_DONE : ST_REST;
          end
        end
        ST_REST: begin
          if (newCnt == needBytes_q) begin
            state_q <= ST_DONE;
          end
        end
        default: state_q <= state_q;
      endcase
    end else if (state_q == ST_DONE && outFree) begin
      state_q <= ST_FIRST;
      insnStart_q <= fetchPc_q;
      byteCnt_q <= BYTES_NONE;
    end
  end

  // Hand-over register; held until accepted or flushed by a redirect
  always_ff @(posedge sys_clk or negedge rstn_q) begin
    if (!rstn_q) begin
      insnValid_q <= 1'b0;
      insn_q <= '0;
      pcNext_q <= '0;
      vecAck_q <= 1'b0;
    end else begin
      vecAck_q <= vecStart;
      // Relative base follows the instruction execution took, not one merely shown
      if (insnValid_q && insnAccept) begin
        pcNext_q <= insn_q.addr + ADDR_W'({insn_q.words, 1'b0});
      end
      if (redirect.valid) begin
        insnValid_q <= 1'b0;
      end else if (state_q == ST_DONE && outFree) begin
        insnValid_q <= 1'b1;
        insn_q <= packInsn(buf_q, needBytes_q, insnStart_q);
      end else if (insnAccept) begin
        insnValid_q <= 1'b0;
      end
    end
  end

  assign memReq = memReq_q;
  assign execAck = execAck_q;
  assign execRdata = execRdata_q;
  assign insnValid = insnValid_q;
  assign insn = insn_q;
  assign vecAck = vecAck_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn_q);

  sequence sFirstWord;
    state_q == ST_FIRST && take && newCnt == BYTES_WORD;
  endsequence
  sequence sHandOver;
    state_q == ST_DONE && outFree && !redirect.valid;
  endsequence

  chk_first_sizes: assert property (sFirstWord |=>
    (state_q == ST_REST || state_q == ST_DONE)
    && needBytes_q == bytesFor($past(newBuf[WORD_W-1:0])))
    else $error("first word did not size the instruction");
  chk_hand_over: assert property (sHandOver |=> insnValid_q
    && insn_q.addr == $past(insnStart_q) && state_q == ST_FIRST)
    else $error("completed instruction not presented");
  chk_word_count: assert property (insnValid_q |->
    insn_q.words >= 2'h1 && insn_q.words <= 2'h3)
    else $error("instruction length out of range");
  chk_even_start: assert property (insnValid_q |-> !insn_q.addr[0])
    else $error("instruction at odd address");
  chk_insn_hold: assert property (insnValid_q && !insnAccept
    && !redirect.valid |=> insnValid_q && $stable(insn_q))
    else $error("held instruction changed before acceptance");
  chk_redirect_flush: assert property (redirect.valid |=>
    fetchPc_q == $past(redirTarget) && byteCnt_q == BYTES_NONE
    && !insnValid_q)
    else $error("redirect did not restart fetch");
  chk_pc_advance: assert property (take && state_q != ST_VEC
    |=> fetchPc_q == $past(fetchPc_q) + ADDR_W'($past(got)))
    else $error("program counter did not advance by bytes read");
  chk_dual_bus: assert property (execWant && fetchNeed
    && execBus != fetchBus && &busFree |=> &{memReq_q[0].req, memReq_q[1].req})
    else $error("fetch and data access not run together");
  chk_vector_load: assert property (state_q == ST_VEC && take
    && newCnt == BYTES_VEC |=> state_q == ST_FIRST
    && fetchPc_q == $past(newBuf[ADDR_W-1:0]))
    else $error("vector not loaded into program counter");
endmodule

// file: common/fetch_pkg.sv
package fetch_pkg;
  localparam int ADDR_W = 32;
  localparam int WORD_W = 16;
  localparam int NUM_BUS = 2;
  localparam int BUF_W = 48;
  // Address bit that picks the memory bus for an access
  localparam int BUS_SEL_BIT = 23;
  // Field of the first word that sizes the instruction
  localparam int LEN_LSB = 14;
  localparam logic [1:0] LEN_ONE_WORD = 2'h0;
  localparam logic [1:0] LEN_TWO_WORDS = 2'h1;
  localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 32'h0000_0000;
  localparam logic [2:0] BYTES_NONE = 3'h0;
  localparam logic [2:0] BYTES_ONE = 3'h1;
  localparam logic [2:0] BYTES_WORD = 3'h2;
  localparam logic [2:0] BYTES_VEC = 3'h4;
  localparam logic [2:0] BYTES_TWO_WORDS = 3'h4;
  localparam logic [2:0] BYTES_MAX = 3'h6;

  typedef enum logic [1:0] {
    ST_VEC = 2'h0,
    ST_FIRST = 2'h1,
    ST_REST = 2'h3,
    ST_DONE = 2'h2
  } fetch_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0] words;
    logic [WORD_W-1:0] op;
    logic [WORD_W-1:0] ext1;
    logic [WORD_W-1:0] ext2;
  } insn_t;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic ack;
    logic narrow;
    logic [WORD_W-1:0] rdata;
  } mem_rsp_t;

  typedef struct packed {
    logic valid;
    logic relative;
    logic [ADDR_W-1:0] target;
  } redirect_t;
endpackage

// file: testbench/mem_model.sv
`timescale 1ns/1ps
module mem_model
  import fetch_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Memory buses
  input wire mem_req_t [NUM_BUS-1:0] memReq,
  output mem_rsp_t [NUM_BUS-1:0] memRsp,
  // Two wait states per access when set
  input wire logic [NUM_BUS-1:0] slow
);
  // Read-only contents; byte 3 of each long is even so vectors stay aligned
  function automatic logic [7:0] byteAt(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = a[7:0] * 8'h3B ^ a[15:8] ^ a[23:16];
    if (a[31:2] == 30'h0) b = (a[1:0] == 2'h2) ? 8'h01 : 8'h00;
    if (a[1:0] == 2'h3) b[0] = 1'b0;
    return b;
  endfunction

  // Bus 1 is the 8-bit bus; idle data toggles so stale bytes never match
  for (genvar b = 0; b < NUM_BUS; b++) begin : g_bus
    logic [1:0] waitCnt = 2'h0;
    logic [WORD_W-1:0] lastData = 16'h0;
    logic [ADDR_W-1:0] a;
    mem_rsp_t rsp;
    assign a = memReq[b].addr;
    always_comb begin
      rsp.ack = memReq[b].req && (!slow[b] || waitCnt == 2'h2);
      rsp.narrow = (b == 1);
      rsp.rdata = ~lastData;
      if (rsp.ack && rsp.narrow) begin
        rsp.rdata = {~lastData[15:8], byteAt(a)};
      end else if (rsp.ack) begin
        rsp.rdata = {byteAt({a[31:1], 1'b0}), byteAt({a[31:1], 1'b1})};
      end
    end
    assign memRsp[b] = rsp;
    always_ff @(posedge sys_clk) begin
      waitCnt <= (memReq[b].req && !rsp.ack) ? waitCnt + 2'h1 : 2'h0;
      lastData <= rsp.rdata;
    end
  end
endmodule

// file: testbench/instruction_fetch_front_end_test.sv
`timescale 1ns/1ps
module instruction_fetch_front_end_test
  import fetch_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  mem_req_t [NUM_BUS-1:0] memReq;
  mem_rsp_t [NUM_BUS-1:0] memRsp;
  mem_req_t execReq = '0;
  logic execAck, insnValid, vecAck;
  logic [WORD_W-1:0] execRdata;
  insn_t insn, prevInsn;
  logic insnAccept = 1'b0;
  redirect_t redirect = '0;
  logic vecReq = 1'b0;
  logic [ADDR_W-1:0] vecAddr = '0;
  logic [NUM_BUS-1:0] slow = '0;
  logic [ADDR_W-1:0] expPc, oldPc;
  int seed = 88662;
  int error_cnt = 0;
  int total_checks = 0;
  int handed = 0;
  bit execOn = 1'b0, held = 1'b0, vecSeen = 1'b0, vecSkip = 1'b0;

  always #5 sys_clk = ~sys_clk;

  instruction_fetch_front_end i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .memReq(memReq), .memRsp(memRsp),
    .execReq(execReq), .execAck(execAck), .execRdata(execRdata),
    .insnValid(insnValid), .insn(insn), .insnAccept(insnAccept),
    .redirect(redirect), .vecReq(vecReq), .vecAddr(vecAddr), .vecAck(vecAck));

  mem_model i_mem (.sys_clk(sys_clk), .memReq(memReq), .memRsp(memRsp),
    .slow(slow));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [31:0] rd32(input logic [ADDR_W-1:0] a);
    return {i_mem.byteAt(a), i_mem.byteAt(a + 1), i_mem.byteAt(a + 2),
      i_mem.byteAt(a + 3)};
  endfunction

  function automatic insn_t expInsn(input logic [ADDR_W-1:0] a);
    insn_t e;
    logic [WORD_W-1:0] w [3];
    for (int i = 0; i < 3; i++) begin
      w[i] = {i_mem.byteAt(a + 2 * i), i_mem.byteAt(a + 2 * i + 1)};
    end
    e = '0;
    e.addr = a;
    e.op = w[0];
    e.words = w[0][15] ? 2'h3 : (w[0][14] ? 2'h2 : 2'h1);
    if (e.words > 2'h1) e.ext1 = w[1];
    if (e.words > 2'h2) e.ext2 = w[2];
    return e;
  endfunction

  // One cycle of the hand-over, sampled mid-cycle where outputs are settled
  task automatic step(input bit mayAccept);
    @(negedge sys_clk);
    vecSeen = (vecAck === 1'b1);
    if (held && insnValid === 1'b1) check(insn, prevInsn);
    held = (insnValid === 1'b1) && !insnAccept;
    prevInsn = insn;
    if (insnValid === 1'b1 && insnAccept) begin
      handed++;
      if (vecSkip && insn.addr === oldPc) begin
        vecSkip = 1'b0;
      end else begin
        vecSkip = 1'b0;
        check(insn, expInsn(expPc));
        check(insn.addr[0], 1'b0);
        expPc = expPc + 2 * insn.words;
      end
    end
    @(posedge sys_clk);
    insnAccept <= mayAccept && ($random(seed) % 3 != 0);
    slow <= NUM_BUS'($random(seed));
  endtask

  // Execution unit data traffic on the 16-bit bus, racing the fetches
  initial begin
    logic [ADDR_W-1:0] a;
    logic w;
    int k;
    wait (execOn);
    forever begin
      a = ADDR_W'($random(seed)) & 32'h0000_FFFE;
      w = $random(seed);
      @(posedge sys_clk);
      execReq <= '{req: 1'b1, addr: a, we: w, wdata: 16'hA5C3};
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (execAck !== 1'b1 && k < 50);
      check(k < 50, 1'b1);
      if (!w)
        check(execRdata, {i_mem.byteAt(a), i_mem.byteAt(a + 1)});
      @(posedge sys_clk);
      execReq <= '0;
    end
  end

  initial begin
    int k;
    logic [ADDR_W-1:0] t;
    fork
      begin
        #100000;
        error_cnt++;
        end_of_test();
      end
    join_none
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    expPc = rd32(RESET_VEC_ADDR);
    execOn = 1'b1;
    repeat (300) step(1);
    check(handed > 20, 1'b1);
    // Redirects, alternately absolute and relative, some onto the byte bus
    for (int i = 0; i < 12; i++) begin
      t = ADDR_W'($random(seed)) & 32'h0080_0FFE;
      step(0);
      redirect <= '{valid: 1'b1, relative: i[0], target: t};
      @(posedge sys_clk);
      redirect <= '0;
      expPc = i[0] ? expPc + t : t;
      held = 1'b0;
      @(negedge sys_clk);
      check(insnValid, 1'b0);
      repeat (60) step(1);
    end
    // Vector reads from both buses; a word already held may still go first
    for (int i = 0; i < 2; i++) begin
      step(1);
      vecAddr <= i[0] ? 32'h0080_0140 : 32'h0000_0040;
      vecReq <= 1'b1;
      k = 0;
      do begin
        step(1);
        k++;
      end while (!vecSeen && k < 200);
      check(vecSeen, 1'b1);
      vecReq <= 1'b0;
      oldPc = expPc;
      vecSkip = 1'b1;
      expPc = rd32(vecAddr);
      repeat (150) step(1);
    end
    end_of_test();
  end
endmodule
